// file: spf_pkg.sv
// spf_pkg: constants and carrier types for the sequencer plane and font control block.
// assumes an 8-bit indexed i/o port pair; all users import spf_pkg::*.
package spf_pkg;
	// port select: 0 = index port, 1 = data port
	localparam logic PORT_INDEX = 1'b0;
	localparam logic PORT_DATA = 1'b1;
	localparam logic [2:0] IDX_PLANE_MASK = 3'h2;
	localparam logic [2:0] IDX_FONT_SEL = 3'h3;
	localparam logic [2:0] IDX_MEM_MODE = 3'h4;
	localparam logic [2:0] IDX_CNT_HOLD = 3'h7;
	localparam logic [2:0] IDX_RESET_VAL = 3'h0;
	localparam logic [7:0] PLANE_MASK_RESET = 8'h00;
	localparam logic [7:0] FONT_SEL_RESET = 8'h00;
	localparam logic [7:0] MEM_MODE_RESET = 8'h00;
	localparam logic [7:0] CNT_HOLD_RESET = 8'h00;
	localparam logic [7:0] PLANE_MASK_WMASK = 8'h0F;
	localparam logic [7:0] FONT_SEL_WMASK = 8'h3F;
	localparam logic [7:0] MEM_MODE_WMASK = 8'h0E;
	localparam logic [7:0] CNT_HOLD_WMASK = 8'hFF;
	localparam int FONT_B_HI = 3;
	localparam int FONT_B_LO = 2;
	localparam int FONT_B_LSB = 5;
	localparam int FONT_A_HI = 1;
	localparam int FONT_A_LO = 0;
	localparam int FONT_A_LSB = 4;
	localparam int MM_CHAIN4 = 3;
	localparam int MM_ODDEVEN = 2;
	localparam int MM_EXTMEM = 1;
	localparam int FONT_TABLE_SHIFT = 13;
	localparam int LIMIT_64K_BITS = 16;
	localparam int HADDR_W = 18;

	typedef struct packed {
		logic [7:0] plane_mask;
		logic [7:0] font_sel;
		logic [7:0] mem_mode;
		logic [7:0] cnt_hold;
	} spf_regs_t;

	typedef struct packed {
		logic [HADDR_W-1:0] addr;
		logic [3:0] planes;
		logic valid;
	} spf_mem_t;

	typedef struct packed {
		logic [2:0] index;
		logic [7:0] rdata;
		logic hold;
		spf_mem_t mem;
		logic [2:0] font_a;
		logic [2:0] font_b;
		logic [15:0] font_a_base;
		logic [15:0] font_b_base;
		logic font_switch;
		logic intensity;
		logic attr_font_sel;
	} spf_state_t;
endpackage : spf_pkg

// file: spf_regfile.sv
// spf_regfile: the four sequencer data registers with reserved bits masked.
// assumes writes are qualified by the caller; reads are combinational from flops.
`timescale 1ns/1ps
module spf_regfile
	import spf_pkg::*;
(
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic rstn_i,
	// write side
	input wire logic wr_i,
	input wire logic [2:0] idx_i,
	input wire logic [7:0] wdata_i,
	// register contents
	output spf_regs_t regs_o
);
	spf_regs_t regs_q;
	spf_regs_t regs_d;

	function automatic logic [7:0] merge(input logic [7:0] wmask, input logic [7:0] wd);
		merge = wd & wmask;
	endfunction : merge

	always_comb begin
		regs_d = regs_q;
		if (wr_i) begin
			case (idx_i)
				IDX_PLANE_MASK: regs_d.plane_mask = merge(PLANE_MASK_WMASK, wdata_i);
				IDX_FONT_SEL: regs_d.font_sel = merge(FONT_SEL_WMASK, wdata_i);
				IDX_MEM_MODE: regs_d.mem_mode = merge(MEM_MODE_WMASK, wdata_i);
				IDX_CNT_HOLD: regs_d.cnt_hold = merge(CNT_HOLD_WMASK, wdata_i);
				default: regs_d = regs_q;
			endcase
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rstn_i) begin
			regs_q <= '{PLANE_MASK_RESET, FONT_SEL_RESET, MEM_MODE_RESET, CNT_HOLD_RESET};
		end else begin
			regs_q <= regs_d;
		end
	end

	assign regs_o = regs_q;
endmodule : spf_regfile

// file: spf_seq_ctrl.sv
// spf_seq_ctrl: sequencer plane mask, font select, memory mode and counter hold.
// assumes one host i/o access per cycle on the index/data pair, synchronous to ref_clk_i.
`timescale 1ns/1ps
module spf_seq_ctrl
	import spf_pkg::*;
(
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic rstn_i,
	// host i/o port pair
	input wire logic io_wr_i,
	input wire logic io_rd_i,
	input wire logic io_port_i,
	input wire logic [7:0] io_wdata_i,
	output logic [7:0] io_rdata_o,
	// host frame buffer access
	input wire logic fb_req_i,
	input wire logic fb_we_i,
	input wire logic [HADDR_W-1:0] fb_addr_i,
	output logic fb_valid_o,
	output logic [HADDR_W-1:0] fb_addr_o,
	output logic [3:0] fb_planes_o,
	// text attribute path
	input wire logic attr_bit3_i,
	output logic attr_font_sel_o,
	output logic attr_intensity_o,
	output logic font_switch_o,
	// font and counter control
	output logic [2:0] font_a_o,
	output logic [2:0] font_b_o,
	output logic [15:0] font_a_base_o,
	output logic [15:0] font_b_base_o,
	output logic counter_hold_o
);
	spf_regs_t regs;
	spf_state_t st_q;
	spf_state_t st_d;
	logic reg_wr;

	// data port write hits selected register
	assign reg_wr = io_wr_i && (io_port_i == PORT_DATA);

	spf_regfile u_regs (
		.ref_clk_i(ref_clk_i),
		.rstn_i(rstn_i),
		.wr_i(reg_wr),
		.idx_i(st_q.index),
		.wdata_i(io_wdata_i),
		.regs_o(regs)
	);

	// without extended memory the upper selector bits read as zero
	function automatic logic [2:0] font_sel(input logic hi1, input logic hi0, input logic lsb,
						input logic ext);
		font_sel = ext ? {hi1, hi0, lsb} : {2'b00, lsb};
	endfunction : font_sel

	// table base within plane 2, in bytes
	function automatic logic [15:0] font_base(input logic [2:0] v);
		font_base = 16'({13'h0000, v} << FONT_TABLE_SHIFT);
	endfunction : font_base

	always_comb begin
		logic ext;
		logic chain;
		logic oddeven_seq;
		logic [3:0] sel;
		ext = regs.mem_mode[MM_EXTMEM];
		chain = regs.mem_mode[MM_CHAIN4];
		oddeven_seq = regs.mem_mode[MM_ODDEVEN];
		sel = 4'h0;
		st_d = st_q;

		if (io_wr_i && io_port_i == PORT_INDEX) begin
			st_d.index = io_wdata_i[2:0];
		end

		// hold set by hold register write
		if (reg_wr && st_q.index == IDX_CNT_HOLD) begin
			st_d.hold = 1'b1;
		end else if (reg_wr) begin
			st_d.hold = 1'b0;
		end

		if (io_rd_i) begin
			if (io_port_i == PORT_INDEX) begin
				st_d.rdata = {5'h00, st_q.index};
			end else begin
				case (st_q.index)
					IDX_PLANE_MASK: st_d.rdata = regs.plane_mask;
					IDX_FONT_SEL: st_d.rdata = regs.font_sel;
					IDX_MEM_MODE: st_d.rdata = regs.mem_mode;
					IDX_CNT_HOLD: st_d.rdata = regs.cnt_hold;
					default: st_d.rdata = 8'h00;
				endcase
			end
		end

		st_d.font_b = font_sel(regs.font_sel[FONT_B_HI], regs.font_sel[FONT_B_LO],
			regs.font_sel[FONT_B_LSB], ext);
		st_d.font_a = font_sel(regs.font_sel[FONT_A_HI], regs.font_sel[FONT_A_LO],
			regs.font_sel[FONT_A_LSB], ext);
		st_d.font_a_base = font_base(st_d.font_a);
		st_d.font_b_base = font_base(st_d.font_b);

		st_d.font_switch = (st_d.font_a != st_d.font_b);
		st_d.attr_font_sel = st_d.font_switch ? attr_bit3_i : 1'b0;
		st_d.intensity = st_d.font_switch ? 1'b0 : attr_bit3_i;

		// plane steering for host frame buffer access
		if (chain) begin
			sel = 4'(4'h1 << fb_addr_i[1:0]);
		end else if (!oddeven_seq && fb_we_i) begin
			sel = fb_addr_i[0] ? 4'hA : 4'h5;
		end else begin
			sel = 4'hF;
		end
		if (fb_we_i) begin
			sel = sel & regs.plane_mask[3:0];
		end

		st_d.mem.valid = fb_req_i;
		st_d.mem.planes = fb_req_i ? sel : 4'h0;
		st_d.mem.addr = ext ? fb_addr_i : {2'b00, fb_addr_i[LIMIT_64K_BITS-1:0]};
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rstn_i) begin
			st_q <= '0;
			st_q.index <= IDX_RESET_VAL;
		end else begin
			st_q <= st_d;
		end
	end

	assign io_rdata_o = st_q.rdata;
	assign fb_valid_o = st_q.mem.valid;
	assign fb_addr_o = st_q.mem.addr;
	assign fb_planes_o = st_q.mem.planes;
	assign attr_font_sel_o = st_q.attr_font_sel;
	assign attr_intensity_o = st_q.intensity;
	assign font_switch_o = st_q.font_switch;
	assign font_a_o = st_q.font_a;
	assign font_b_o = st_q.font_b;
	assign font_a_base_o = st_q.font_a_base;
	assign font_b_base_o = st_q.font_b_base;
	// one hold stops horizontal and, through it, vertical counting
	assign counter_hold_o = st_q.hold;
endmodule : spf_seq_ctrl

// file: spf_props.sv
// spf_props: port-level assertions for spf_seq_ctrl.
// assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/1ps
module spf_props
	import spf_pkg::*;
(
	// watched ports
	input wire logic ref_clk_i,
	input wire logic rstn_i,
	input wire logic io_wr_i,
	input wire logic fb_req_i,
	input wire logic fb_we_i,
	input wire logic [HADDR_W-1:0] fb_addr_i,
	input wire logic fb_valid_o,
	input wire logic [HADDR_W-1:0] fb_addr_o,
	input wire logic [3:0] fb_planes_o,
	input wire logic attr_bit3_i,
	input wire logic attr_font_sel_o,
	input wire logic attr_intensity_o,
	input wire logic font_switch_o,
	input wire logic [2:0] font_a_o,
	input wire logic [2:0] font_b_o,
	input wire logic [15:0] font_a_base_o,
	input wire logic [15:0] font_b_base_o,
	input wire logic counter_hold_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!rstn_i);
	a_font_differ: assert property (font_switch_o == (font_a_o != font_b_o))
		else $error("font switch wrong");
	a_attr_font: assert property ($past(rstn_i) |-> attr_font_sel_o ==
		($past(attr_bit3_i) && font_switch_o)) else $error("attr font select wrong");
	a_attr_bright: assert property ($past(rstn_i) |-> attr_intensity_o ==
		($past(attr_bit3_i) && !font_switch_o)) else $error("intensity wrong");
	a_font_base: assert property (font_a_base_o == {font_a_o, 13'h0000} &&
		font_b_base_o == {font_b_o, 13'h0000}) else $error("font base wrong");
	a_fb_forward: assert property (fb_req_i |=> fb_valid_o &&
		fb_addr_o[15:0] == $past(fb_addr_i[15:0])) else $error("access not forwarded");
	a_idle_planes: assert property (!fb_valid_o |-> fb_planes_o == 4'h0)
		else $error("planes without request");
	a_read_planes: assert property (fb_req_i && !fb_we_i |=> fb_planes_o == 4'hF ||
		fb_planes_o == 4'h1 << $past(fb_addr_i[1:0])) else $error("read planes wrong");
	a_quiet_regs: assert property (!io_wr_i ##1 !io_wr_i |=>
		$stable({font_a_o, font_b_o, counter_hold_o})) else $error("change without write");
endmodule : spf_props
bind spf_seq_ctrl spf_props i_spf_props(.*);

// file: spf_tb.sv
// spf_tb: self-checking bench for spf_seq_ctrl.
// assumes the checker is bound from spf_props.sv.
`timescale 1ns/1ps
module tb
	import spf_pkg::*;
;
	logic ref_clk_i = 0, rstn_i = 0, io_wr_i = 0, io_rd_i = 0, io_port_i = 0;
	logic fb_req_i = 0, fb_we_i = 0, attr_bit3_i = 0;
	logic [7:0] io_wdata_i = 8'h00, io_rdata_o, d, mm;
	logic [HADDR_W-1:0] fb_addr_i = '0, fb_addr_o;
	logic fb_valid_o, attr_font_sel_o, attr_intensity_o, font_switch_o, counter_hold_o;
	logic [3:0] fb_planes_o;
	logic [2:0] font_a_o, font_b_o, a, b;
	logic [15:0] font_a_base_o, font_b_base_o;
	logic [7:0] wm [4] = '{PLANE_MASK_WMASK, FONT_SEL_WMASK, MEM_MODE_WMASK, CNT_HOLD_WMASK};
	int fails = 0, comparisons = 0;
	always #20 ref_clk_i = ~ref_clk_i;
	spf_seq_ctrl i_spf_seq_ctrl(.*);
	task automatic chk(input string n, input logic [17:0] e, input logic [17:0] s);
		comparisons++;
		if (s !== e) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	// strobes rise and fall on falling edges, one idle cycle between accesses
	task automatic io(input logic w, input logic p, input logic [7:0] v);
		@(negedge ref_clk_i);
		io_wr_i = w;
		io_rd_i = !w;
		io_port_i = p;
		io_wdata_i = v;
		@(negedge ref_clk_i);
		io_wr_i = 0;
		io_rd_i = 0;
	endtask : io
	task automatic wreg(input logic [7:0] i, input logic [7:0] v);
		io(1, 0, i);
		io(1, 1, v);
	endtask : wreg
	function automatic logic [3:0] ep(logic [7:0] m, logic [7:0] md, logic [17:0] ad, logic w);
		logic [3:0] p;
		if (md[3]) p = 4'h1 << ad[1:0];
		else if (!md[2] && w) p = ad[0] ? 4'hA : 4'h5;
		else p = 4'hF;
		return w ? p & m[3:0] : p;
	endfunction : ep
	function automatic logic [2:0] efont(logic [1:0] hi, logic lo, logic ext);
		return {ext ? hi : 2'b00, lo};
	endfunction : efont
	task automatic report_and_stop;
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : report_and_stop
	initial begin
		void'($urandom(91847));
		repeat (4) @(posedge ref_clk_i);
		@(negedge ref_clk_i);
		rstn_i = 1;
		io(0, 0, 0);
		chk("index", 8'h00, io_rdata_o);
		io(1, 0, 8'hFA);
		io(0, 0, 0);
		chk("index", 8'h02, io_rdata_o);
		for (int k = 0; k < 8; k++) begin
			d = k ? 8'($urandom) : 8'hFF;
			wreg(k % 4 == 3 ? 8'h07 : 8'(k % 4 + 2), d);
			io(0, 1, 0);
			chk("readback", d & wm[k % 4], io_rdata_o);
		end
		wreg(8'h05, 8'hFF);
		io(0, 1, 0);
		chk("unused", 8'h00, io_rdata_o);
		for (int k = 0; k < 12; k++) begin
			d = k ? 8'($urandom) : 8'h3F;
			mm = k ? 8'($urandom) : 8'h02;
			wreg(8'h04, mm);
			wreg(8'h03, d);
			attr_bit3_i = 1'($urandom);
			repeat (2) @(negedge ref_clk_i);
			a = efont(d[1:0], d[4], mm[1]);
			b = efont(d[3:2], d[5], mm[1]);
			chk("font_a", a, font_a_o);
			chk("font_b", b, font_b_o);
			chk("base_a", {a, 13'h0000}, font_a_base_o);
			chk("base_b", {b, 13'h0000}, font_b_base_o);
			chk("switch", a != b, font_switch_o);
			chk("attr_font", attr_bit3_i && a != b, attr_font_sel_o);
			chk("intensity", attr_bit3_i && a == b, attr_intensity_o);
		end
		for (int k = 0; k < 24; k++) begin
			d = 8'($urandom);
			mm = k < 4 ? 8'(k * 4 + 2) : 8'($urandom);
			wreg(8'h02, d);
			wreg(8'h04, mm);
			fb_req_i = 1;
			fb_we_i = k < 4 ? 1'b1 : 1'($urandom);
			fb_addr_i = 18'($urandom);
			@(negedge ref_clk_i);
			chk("planes", ep(d, mm, fb_addr_i, fb_we_i), fb_planes_o);
			chk("addr", mm[1] ? fb_addr_i : {2'b00, fb_addr_i[15:0]}, fb_addr_o);
			chk("valid", 1'b1, fb_valid_o);
			fb_req_i = 0;
		end
		@(negedge ref_clk_i);
		chk("idle", 4'h0, fb_planes_o);
		chk("idle_valid", 1'b0, fb_valid_o);
		for (int k = 0; k < 4; k++) begin
			wreg(8'h07, 8'($urandom));
			@(negedge ref_clk_i);
			chk("hold", 1'b1, counter_hold_o);
			io(1, 0, 8'(k ? $urandom % 7 : 6));
			chk("hold", 1'b1, counter_hold_o);
			io(1, 1, 8'h00);
			@(negedge ref_clk_i);
			chk("hold", 1'b0, counter_hold_o);
		end
		report_and_stop;
	end
	initial begin
		#1000000;
		fails++;
		report_and_stop;
	end
endmodule : tb
